/* File: inc/lsag_pkg.sv */
// load/store address generator: shared constants and types
// assumes a 16-entry register file with the stack pointer at 13 and the program counter at 15
`default_nettype none
package lsag_pkg;
    // register file shape
    localparam int unsigned LSAG_NREG = 16;
    localparam int unsigned LSAG_IDX_W = 4;
    localparam int unsigned LSAG_DW = 32;
    localparam logic [3:0] LSAG_REG_PC = 4'hf;
    localparam logic [3:0] LSAG_REG_SP = 4'hd;
    // addressing figures
    localparam logic [31:0] LSAG_WORD_STEP = 32'h4;
    localparam logic [1:0] LSAG_SHIFT_MAX = 2'h3;
    localparam int unsigned LSAG_UNPRIV_IMM_W = 8;
    localparam int unsigned LSAG_PCREL_IMM_W = 13;
    localparam logic [31:0] LSAG_ALIGN_MASK = 32'hffff_fffe;
    // instruction forms
    typedef enum logic [2:0] {
        LSAG_K_REGOFS = 3'b000,
        LSAG_K_UNPRIV = 3'b001,
        LSAG_K_PCREL = 3'b010,
        LSAG_K_PAIR = 3'b011,
        LSAG_K_MULTI = 3'b100
    } lsag_kind_t;
    // transfer sizes
    typedef enum logic [2:0] {
        LSAG_SZ_WORD = 3'b000,
        LSAG_SZ_UBYTE = 3'b001,
        LSAG_SZ_SBYTE = 3'b010,
        LSAG_SZ_UHALF = 3'b011,
        LSAG_SZ_SHALF = 3'b100
    } lsag_size_t;
    // sequencer states
    typedef enum logic [1:0] {
        LSAG_ST_IDLE = 2'b00,
        LSAG_ST_ISSUE = 2'b01,
        LSAG_ST_ACCESS = 2'b10,
        LSAG_ST_BASEWB = 2'b11
    } lsag_state_t;
    // memory size codes on the data port
    localparam logic [1:0] LSAG_MSZ_BYTE = 2'h0;
    localparam logic [1:0] LSAG_MSZ_HALF = 2'h1;
    localparam logic [1:0] LSAG_MSZ_WORD = 2'h2;
endpackage
`default_nettype wire

/* File: verilog/lsag_extend.sv */
// load data extension: byte / halfword to 32 bits, signed or unsigned
// assumes the addressed datum sits in the low lanes of the read word
`timescale 1ns/1ps
`default_nettype none
module lsag_extend
    import lsag_pkg::*;
(
    // raw data and size
    input wire logic [31:0] raw_data,
    input wire lsag_size_t size,
    // extended result
    output logic [31:0] ext_data
);
    // pure mux, no state
    always_comb begin
        case (size)
            LSAG_SZ_SBYTE: ext_data = {{24{raw_data[7]}}, raw_data[7:0]};
            LSAG_SZ_UBYTE: ext_data = {24'h00_0000, raw_data[7:0]};
            LSAG_SZ_SHALF: ext_data = {{16{raw_data[15]}}, raw_data[15:0]};
            LSAG_SZ_UHALF: ext_data = {16'h0000, raw_data[15:0]};
            default: ext_data = raw_data; // word passes whole
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/lsag_reglist.sv */
// register-list picker: lowest or highest set bit of a mask, plus a count
// assumes the mask is at most NREG bits; an empty mask gives index 0, count 0
`timescale 1ns/1ps
`default_nettype none
module lsag_reglist
    import lsag_pkg::*;
#(
    parameter int unsigned NREG = LSAG_NREG,
    parameter int unsigned IW = LSAG_IDX_W
) (
    // list in
    input wire logic [NREG-1:0] mask,
    input wire logic pick_high,
    // picks out
    output logic [IW-1:0] pick_idx,
    output logic [IW:0] count
);
    logic [NREG:0] seen_lo; // any bit below position
    logic [NREG:0] seen_hi; // any bit at or above position
    logic [NREG-1:0] lo_hit; // one-hot lowest
    logic [NREG-1:0] hi_hit; // one-hot highest
    assign seen_lo[0] = 1'b0;
    assign seen_hi[NREG] = 1'b0;
    // per-bit priority chains from each end
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_bit
            assign lo_hit[g] = mask[g] & ~seen_lo[g];
            assign seen_lo[g+1] = seen_lo[g] | mask[g];
            assign hi_hit[g] = mask[g] & ~seen_hi[g+1];
            assign seen_hi[g] = seen_hi[g+1] | mask[g];
        end
    endgenerate
    // encode the chosen one-hot and count the set bits
    always_comb begin
        pick_idx = '0;
        count = '0;
        for (int i = 0; i < NREG; i++) begin
            if (pick_high ? hi_hit[i] : lo_hit[i]) begin
                pick_idx = IW'(i);
            end
            count = count + (IW+1)'(mask[i]);
        end
    end
endmodule
`default_nettype wire

/* File: verilog/lsag_core.sv */
// load/store address generator and sequencer for single, paired and multiple transfers
// assumes the decoder supplies register values, and the register file a same-cycle read port
// Notes on behaviour
// - register-offset address is base plus shifted offset
// - signed byte/half loads sign-extend to 32
// - unsigned loads zero-extend; default size is word
// - load into pc branches, bit zero cleared
// - condition flags never change here
// - unprivileged form adds 0..255 immediate
// - unprivileged form marks access unprivileged
// - unprivileged software sees ordinary immediate behaviour
// - pc-relative offsets span 4095, pairs 1020
// - increment_after_mode walks up, lowest register first
// - increment writeback is base plus 4(n-1)
// - decrement_before_mode walks down, highest register highest
// - decrement order descending, writeback base minus 4(n-1)
// - multiple transfers always move whole words
`timescale 1ns/1ps
`default_nettype none
module lsag_core
    import lsag_pkg::*;
#(
    parameter int unsigned NREG = LSAG_NREG
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // command from the decoder
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire lsag_kind_t cmd_kind,
    input wire logic cmd_load,
    input wire lsag_size_t cmd_size,
    input wire logic [31:0] cmd_base_val,
    input wire logic [3:0] cmd_base_idx,
    input wire logic [31:0] cmd_offset_val,
    input wire logic [1:0] cmd_shift,
    input wire logic [12:0] cmd_imm,
    input wire logic [31:0] cmd_pc_val,
    input wire logic [3:0] cmd_xfer_idx,
    input wire logic [3:0] cmd_xfer2_idx,
    input wire logic [NREG-1:0] cmd_reglist,
    input wire logic cmd_decr,
    input wire logic cmd_writeback,
    // register read port for store data
    output logic [3:0] rd_idx,
    input wire logic [31:0] rd_data,
    // data memory port
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_write,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    output logic mem_unpriv,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // register writeback and branch
    output logic wb_valid,
    output logic [3:0] wb_idx,
    output logic [31:0] wb_data,
    output logic branch_valid,
    output logic [31:0] branch_target,
    output logic flags_wr_en,
    output logic done
);
    ////////////////////////////////////////////////////////////////////////////////
    // held command
    lsag_state_t state_r; // sequencer state
    lsag_kind_t kind_r; // form in flight
    lsag_size_t size_r; // transfer size
    logic load_r, decr_r, wbk_r, beat1_r, br_pend_r; // load, walk down, base writeback, pair beat two, pc loaded
    logic [31:0] base_r, addr_r, br_tgt_r; // base at accept, next beat address, aligned branch target
    logic [3:0] base_idx_r, xfer_r, xfer2_r, cur_r; // base, first and second transfer, register in flight
    logic [NREG-1:0] rem_r; // registers still to move
    logic [4:0] count_r, beats_r, pick_cnt; // list size, beats left, list population
    logic [31:0] addr_nxt, ext_data, base_final; // first-beat address, extended read data, writeback value
    logic [3:0] pick_idx, cur_nxt; // next list register, register for next beat
    logic last_beat, accept; // final beat in flight, command taken
    assign cmd_ready = (state_r == LSAG_ST_IDLE);
    assign accept = ce && cmd_valid && cmd_ready;
    assign last_beat = (beats_r == 5'h01);
    assign flags_wr_en = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    lsag_reglist #(.NREG(NREG), .IW(LSAG_IDX_W)) u_pick (
        .mask(cmd_valid && cmd_ready ? cmd_reglist : rem_r),
        .pick_high(cmd_valid && cmd_ready ? cmd_decr : decr_r),
        .pick_idx(pick_idx),
        .count(pick_cnt)
    );
    lsag_extend u_ext (
        .raw_data(mem_rdata),
        .size(size_r),
        .ext_data(ext_data)
    );
    // first-beat address per form
    always_comb begin
        case (cmd_kind)
            LSAG_K_REGOFS: addr_nxt = cmd_base_val + (cmd_offset_val << cmd_shift);
            // unsigned 8-bit immediate; same sum as ordinary immediate form
            LSAG_K_UNPRIV: addr_nxt = cmd_base_val + {24'h00_0000, cmd_imm[LSAG_UNPRIV_IMM_W-1:0]};
            // signed 13-bit offset covers +-4095 and +-1020
            LSAG_K_PCREL,
            LSAG_K_PAIR: addr_nxt = cmd_pc_val + {{19{cmd_imm[12]}}, cmd_imm};
            default: addr_nxt = cmd_base_val; // multiple starts at base
        endcase
    end
    // register chosen for the next beat
    assign cur_nxt = (kind_r == LSAG_K_MULTI) ? pick_idx : (beat1_r ? xfer2_r : xfer_r);
    assign rd_idx = cur_nxt;
    // up by 4(n-1); down by 4(n-1)
    always_comb begin
        if (decr_r) begin
            base_final = base_r - {25'h000_0000, count_r - 5'h01, 2'h0};
        end else begin
            base_final = base_r + {25'h000_0000, count_r - 5'h01, 2'h0};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= LSAG_ST_IDLE;
        end else if (ce) begin
            case (state_r)
                LSAG_ST_IDLE: begin
                    if (cmd_valid) begin
                        state_r <= LSAG_ST_ISSUE;
                    end
                end
                LSAG_ST_ISSUE: state_r <= LSAG_ST_ACCESS;
                LSAG_ST_ACCESS: begin
                    if (mem_ack && !last_beat) begin
                        state_r <= LSAG_ST_ISSUE;
                    end else if (mem_ack && kind_r == LSAG_K_MULTI && wbk_r) begin
                        state_r <= LSAG_ST_BASEWB;
                    end else if (mem_ack) begin
                        // no base update unless multiple with writeback
                        state_r <= LSAG_ST_IDLE;
                    end
                end
                LSAG_ST_BASEWB: state_r <= LSAG_ST_IDLE;
                default: state_r <= LSAG_ST_IDLE;
            endcase
        end
    end
    // command capture and beat bookkeeping
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kind_r <= LSAG_K_REGOFS;
            size_r <= LSAG_SZ_WORD;
            load_r <= 1'b0;
            decr_r <= 1'b0;
            wbk_r <= 1'b0;
            base_r <= 32'h0000_0000;
            base_idx_r <= 4'h0;
            xfer_r <= 4'h0;
            xfer2_r <= 4'h0;
            rem_r <= '0;
            count_r <= 5'h00;
            beats_r <= 5'h00;
            beat1_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            cur_r <= 4'h0;
        end else if (accept) begin
            kind_r <= cmd_kind;
            // multiple and paired forms force word size
            size_r <= (cmd_kind == LSAG_K_MULTI || cmd_kind == LSAG_K_PAIR) ? LSAG_SZ_WORD : cmd_size;
            // paired form is load-only
            load_r <= cmd_load || cmd_kind == LSAG_K_PAIR;
            decr_r <= cmd_decr && cmd_kind == LSAG_K_MULTI;
            wbk_r <= cmd_writeback && cmd_kind == LSAG_K_MULTI;
            base_r <= cmd_base_val;
            base_idx_r <= cmd_base_idx;
            xfer_r <= cmd_xfer_idx;
            xfer2_r <= cmd_xfer2_idx;
            rem_r <= cmd_reglist;
            count_r <= pick_cnt;
            beat1_r <= 1'b0;
            addr_r <= addr_nxt;
            case (cmd_kind)
                LSAG_K_MULTI: beats_r <= pick_cnt;
                LSAG_K_PAIR: beats_r <= 5'h02;
                default: beats_r <= 5'h01;
            endcase
        end else if (ce && state_r == LSAG_ST_ISSUE) begin
            cur_r <= cur_nxt;
        end else if (ce && state_r == LSAG_ST_ACCESS && mem_ack) begin
            rem_r[cur_r] <= 1'b0;
            beats_r <= beats_r - 5'h01;
            beat1_r <= 1'b1;
            // ascending by a word; descending by a word
            addr_r <= decr_r ? addr_r - LSAG_WORD_STEP : addr_r + LSAG_WORD_STEP;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // memory port, launched from ISSUE and held until acknowledged
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_req <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_write <= 1'b0;
            mem_size <= LSAG_MSZ_WORD;
            mem_wdata <= 32'h0000_0000;
            mem_unpriv <= 1'b0;
        end else if (ce && state_r == LSAG_ST_ISSUE) begin
            mem_req <= 1'b1;
            mem_addr <= addr_r;
            mem_write <= !load_r;
            // forced unprivileged whatever the current level
            mem_unpriv <= (kind_r == LSAG_K_UNPRIV);
            mem_wdata <= rd_data;
            case (size_r)
                LSAG_SZ_UBYTE,
                LSAG_SZ_SBYTE: mem_size <= LSAG_MSZ_BYTE;
                LSAG_SZ_UHALF,
                LSAG_SZ_SHALF: mem_size <= LSAG_MSZ_HALF;
                default: mem_size <= LSAG_MSZ_WORD;
            endcase
        end else if (ce && mem_ack) begin
            mem_req <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // register writeback: loaded data, then the base for multiple writeback
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_valid <= 1'b0;
            wb_idx <= 4'h0;
            wb_data <= 32'h0000_0000;
        end else if (ce) begin
            wb_valid <= 1'b0;
            if (state_r == LSAG_ST_ACCESS && mem_ack && load_r && cur_r != LSAG_REG_PC) begin
                wb_valid <= 1'b1;
                wb_idx <= cur_r;
                wb_data <= ext_data;
            end else if (state_r == LSAG_ST_BASEWB) begin
                // list never holds the base, so this write cannot collide
                wb_valid <= 1'b1;
                wb_idx <= base_idx_r;
                wb_data <= base_final;
            end
        end
    end
    // branch on pc load, issued with completion so later beats still finish
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            br_pend_r <= 1'b0;
            br_tgt_r <= 32'h0000_0000;
            branch_valid <= 1'b0;
            branch_target <= 32'h0000_0000;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            branch_valid <= 1'b0;
            if (accept) begin
                br_pend_r <= 1'b0;
            end else if (state_r == LSAG_ST_ACCESS && mem_ack && load_r && cur_r == LSAG_REG_PC) begin
                // clear bit zero of the loaded value
                br_pend_r <= 1'b1;
                br_tgt_r <= mem_rdata & LSAG_ALIGN_MASK;
            end
            if ((state_r == LSAG_ST_ACCESS && mem_ack && last_beat && !(kind_r == LSAG_K_MULTI && wbk_r))
                || state_r == LSAG_ST_BASEWB) begin
                done <= 1'b1;
                branch_valid <= br_pend_r || (load_r && cur_r == LSAG_REG_PC && state_r == LSAG_ST_ACCESS);
                branch_target <= br_pend_r ? br_tgt_r : mem_rdata & LSAG_ALIGN_MASK;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_REGOFS_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_kind == LSAG_K_REGOFS) ##1 ce
        |=> mem_addr == $past(cmd_base_val, 2) + ($past(cmd_offset_val, 2) << $past(cmd_shift, 2)))
        else $error("register-offset address wrong");
    AST_SEXT: assert property (@(posedge core_clk) disable iff (sys_rst)
        wb_valid && state_r != LSAG_ST_BASEWB && size_r == LSAG_SZ_SBYTE |-> wb_data[31:8] == {24{wb_data[7]}})
        else $error("signed byte not sign-extended");
    AST_ZEXT: assert property (@(posedge core_clk) disable iff (sys_rst)
        wb_valid && kind_r != LSAG_K_MULTI && size_r == LSAG_SZ_UHALF |-> wb_data[31:16] == 16'h0000)
        else $error("unsigned half not zero-extended");
    AST_BRANCH_ALIGN: assert property (@(posedge core_clk) disable iff (sys_rst)
        branch_valid |-> !branch_target[0] && done)
        else $error("branch target not halfword aligned");
    AST_FLAGS: assert property (@(posedge core_clk) disable iff (sys_rst)
        done |-> !flags_wr_en)
        else $error("flags written");
    AST_UNPRIV: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req |-> mem_unpriv == (kind_r == LSAG_K_UNPRIV))
        else $error("unprivileged access not marked");
    AST_UNPRIV_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd_kind == LSAG_K_UNPRIV |=> addr_r == $past(cmd_base_val) + {24'h00_0000, $past(cmd_imm[7:0])})
        else $error("unprivileged address wrong");
    AST_PCREL_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
        accept && cmd_kind == LSAG_K_PCREL |=> $signed(addr_r - $past(cmd_pc_val)) == $signed($past(cmd_imm)))
        else $error("pc-relative address wrong");
    AST_INC_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
        ce && state_r == LSAG_ST_ACCESS && mem_ack && !last_beat && !decr_r ##1 ce |=> mem_addr == $past(mem_addr, 2) + 32'h4)
        else $error("ascending step wrong");
    AST_DEC_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
        ce && state_r == LSAG_ST_ACCESS && mem_ack && !last_beat && decr_r ##1 ce |=> mem_addr == $past(mem_addr, 2) - 32'h4)
        else $error("descending step wrong");
    AST_BASE_WB: assert property (@(posedge core_clk) disable iff (sys_rst)
        ce && state_r == LSAG_ST_BASEWB |=> wb_valid && wb_idx == base_idx_r && done)
        else $error("base writeback missing");
    AST_MULTI_WORD: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req && kind_r == LSAG_K_MULTI |-> mem_size == LSAG_MSZ_WORD)
        else $error("multiple transfer not word sized");
    AST_NO_SINGLE_WB: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == LSAG_ST_BASEWB |-> kind_r == LSAG_K_MULTI)
        else $error("single form wrote base");
    COV_REGOFS_LOAD: cover property (@(posedge core_clk) done && kind_r == LSAG_K_REGOFS && load_r);
    COV_DEC_WB: cover property (@(posedge core_clk) state_r == LSAG_ST_BASEWB && decr_r);
    COV_BRANCH: cover property (@(posedge core_clk) branch_valid);
    COV_PAIR: cover property (@(posedge core_clk) done && kind_r == LSAG_K_PAIR);
endmodule
`default_nettype wire

/* File: dv/lsag_mem_model.sv */
// data memory and register read partner for the address generator
// assumes one request at a time, held until its ack
`timescale 1ns/1ps
`default_nettype none
module lsag_mem_model (
    // clock and stall length
    input wire logic core_clk,
    input wire logic [1:0] slow,
    // memory side
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // register read side
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_data
);
    logic [1:0] wait_r; // stall cycles spent so far
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
        wait_r = 2'h0;
    end
    // register value: its number in every nibble
    assign rd_data = {8{rd_idx}};
    // ack after the stall; idle data toggles so a stale read shows
    always @(posedge core_clk) begin
        if (mem_req && !mem_ack && wait_r == slow) begin
            mem_ack <= 1'b1;
            mem_rdata <= {mem_addr[15:0], mem_addr[31:16]};
            wait_r <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

/* File: dv/lsag_bench.sv */
// self-checking bench for the load/store address generator
// assumes the memory partner lsag_mem_model
`timescale 1ns/1ps
`default_nettype none
module lsag_bench;
    import lsag_pkg::*;
    logic core_clk, sys_rst, cmd_valid, cmd_ready, cmd_load, cmd_decr, cmd_writeback, mem_req, mem_write;
    logic mem_unpriv, mem_ack, wb_valid, branch_valid, flags_wr_en, done, ce;
    lsag_kind_t cmd_kind;
    lsag_size_t cmd_size;
    logic [31:0] cmd_base_val, cmd_offset_val, cmd_pc_val, rd_data, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] wb_data, branch_target, br_t, got_w[$];
    logic [12:0] cmd_imm;
    logic [15:0] cmd_reglist;
    logic [3:0] cmd_base_idx, cmd_xfer_idx, cmd_xfer2_idx, rd_idx, wb_idx;
    logic [1:0] cmd_shift, mem_size, slow;
    logic [35:0] got_a[$], got_x[$];
    integer seed;
    int num_errors, checks, br_n, cyc, i;
    lsag_core u_lsag_core (.core_clk, .sys_rst, .ce, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_load,
        .cmd_size, .cmd_base_val, .cmd_base_idx, .cmd_offset_val, .cmd_shift, .cmd_imm, .cmd_pc_val,
        .cmd_xfer_idx, .cmd_xfer2_idx, .cmd_reglist, .cmd_decr, .cmd_writeback, .rd_idx, .rd_data, .mem_req,
        .mem_addr, .mem_write, .mem_size, .mem_wdata, .mem_unpriv, .mem_ack, .mem_rdata, .wb_valid, .wb_idx,
        .wb_data, .branch_valid, .branch_target, .flags_wr_en, .done);
    lsag_mem_model u_lsag_mem_model (.core_clk, .slow, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .rd_idx,
        .rd_data);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // load data widening by size
    function automatic logic [31:0] ext(logic [31:0] d, lsag_size_t z);
        case (z)
            LSAG_SZ_UBYTE: return {24'h0, d[7:0]};
            LSAG_SZ_SBYTE: return {{24{d[7]}}, d[7:0]};
            LSAG_SZ_UHALF: return {16'h0, d[15:0]};
            LSAG_SZ_SHALF: return {{16{d[15]}}, d[15:0]};
            default: return d;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    // monitor at the falling edge, where registered outputs are settled
    always @(negedge core_clk) begin
        if (mem_req && mem_ack) got_a.push_back({mem_unpriv, mem_write, mem_size, mem_addr});
        if (mem_req && mem_ack && mem_write) got_w.push_back(mem_wdata);
        if (wb_valid) got_x.push_back({wb_idx, wb_data});
        if (branch_valid) br_t = branch_target;
        if (branch_valid) br_n++;
        chk("flags", 36'h0, {35'h0, flags_wr_en});
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // random command within what the stream may legally issue
    task automatic rnd();
        int r;
        r = $random(seed) % 4096;
        cmd_kind = lsag_kind_t'(3'($unsigned($random(seed)) % 5));
        cmd_load = cmd_kind inside {LSAG_K_PCREL, LSAG_K_PAIR} || 1'($random(seed));
        cmd_size = lsag_size_t'(3'($unsigned($random(seed)) % 5));
        {cmd_decr, cmd_writeback, cmd_shift, slow} = 6'($random(seed));
        cmd_base_val = $random(seed);
        cmd_offset_val = $random(seed);
        cmd_pc_val = $random(seed);
        cmd_imm = cmd_kind == LSAG_K_PAIR ? 13'(r / 16 * 4) : 13'(r);
        cmd_base_idx = 4'($unsigned($random(seed)) % 13);
        cmd_xfer_idx = 4'($unsigned($random(seed)) % 12);
        cmd_xfer2_idx = cmd_xfer_idx + 4'h1;
        cmd_reglist = 16'($random(seed)) & 16'h1fff & ~(16'h1 << cmd_base_idx);
        if (cmd_reglist == 16'h0) cmd_reglist = cmd_base_idx == 4'h0 ? 16'h0002 : 16'h0001;
    endtask
    // hand-written corner command
    task automatic cset(lsag_kind_t k, logic ld, logic [12:0] im, logic [3:0] x, logic [15:0] l, logic [1:0] dw);
        cmd_kind = k;
        cmd_load = ld;
        cmd_imm = im;
        cmd_xfer_idx = x;
        cmd_xfer2_idx = x + 4'h1;
        cmd_reglist = l;
        cmd_base_idx = 4'h4;
        {cmd_decr, cmd_writeback} = dw;
        if (x == 4'hf) cmd_size = LSAG_SZ_WORD;
    endtask
    ////////////////////////////////////////////////////////////////
    // run one command and compare every beat against the worked-out walk
    task automatic go();
        logic [31:0] a, s, m, bt, msk, ea[$];
        logic [35:0] xw[$];
        logic [1:0] sc;
        lsag_size_t z;
        int er[$], n, r, xb;
        // signed sizes exist for loads only
        if (!cmd_load && cmd_size inside {LSAG_SZ_SBYTE, LSAG_SZ_SHALF}) cmd_size = lsag_size_t'(cmd_size - 1);
        got_a.delete();
        got_w.delete();
        got_x.delete();
        br_n = 0;
        xb = 0;
        n = 0;
        z = cmd_kind >= LSAG_K_PAIR ? LSAG_SZ_WORD : cmd_size;
        sc = z == LSAG_SZ_WORD ? LSAG_MSZ_WORD : z inside {LSAG_SZ_UBYTE, LSAG_SZ_SBYTE} ? LSAG_MSZ_BYTE : LSAG_MSZ_HALF;
        msk = sc == LSAG_MSZ_BYTE ? 32'hff : sc == LSAG_MSZ_HALF ? 32'hffff : 32'hffff_ffff;
        case (cmd_kind)
            LSAG_K_REGOFS: a = cmd_base_val + (cmd_offset_val << cmd_shift);
            LSAG_K_UNPRIV: a = cmd_base_val + {24'h0, cmd_imm[7:0]};
            LSAG_K_MULTI: a = cmd_base_val;
            default: a = cmd_pc_val + {{19{cmd_imm[12]}}, cmd_imm};
        endcase
        s = (cmd_kind == LSAG_K_MULTI && cmd_decr) ? 32'hffff_fffc : LSAG_WORD_STEP;
        for (int k = 0; k < 16; k++) begin
            r = (cmd_kind == LSAG_K_MULTI && cmd_decr) ? 15 - k : k;
            if (cmd_kind == LSAG_K_MULTI ? cmd_reglist[r] : k < 1 + (cmd_kind == LSAG_K_PAIR)) begin
                er.push_back(cmd_kind == LSAG_K_MULTI ? r : k ? cmd_xfer2_idx : cmd_xfer_idx);
                ea.push_back(a + s * n);
                n++;
            end
        end
        {cmd_valid, ce} = 2'b10;
        @(negedge core_clk);
        chk("frozen ready", 36'h1, {35'h0, cmd_ready});
        ce = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        chk("beats", 36'(n), 36'(got_a.size()));
        foreach (ea[j]) begin
            m = {ea[j][15:0], ea[j][31:16]};
            chk("access", {cmd_kind == LSAG_K_UNPRIV, !cmd_load, sc, ea[j]}, got_a[j]);
            if (!cmd_load) chk("wdata", {4'h0, {8{er[j][3:0]}} & msk}, {4'h0, got_w[j] & msk});
            else if (er[j] == 15) bt = m & LSAG_ALIGN_MASK;
            else xw.push_back({er[j][3:0], ext(m, z)});
            if (cmd_load && er[j] == 15) xb = 1;
        end
        if (cmd_kind == LSAG_K_MULTI && cmd_writeback) xw.push_back({cmd_base_idx, a + s * (n - 1)});
        chk("wb count", 36'(xw.size()), 36'(got_x.size()));
        foreach (xw[j]) chk("wb", xw[j], got_x[j]);
        chk("branches", 36'(xb), 36'(br_n));
        if (xb) chk("target", {4'h0, bt}, {4'h0, br_t});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hc2cd36a4;
        sys_rst = 1'b1;
        {cmd_valid, ce} = 2'b01;
        rnd();
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        for (i = 0; i < 80; i++) begin
            rnd();
            case (i)
                0: cset(LSAG_K_REGOFS, 1'b1, 13'h0, 4'hf, 16'h1, 2'h0);
                1: cset(LSAG_K_UNPRIV, 1'b0, 13'h0ff, 4'h2, 16'h1, 2'h0);
                2: cset(LSAG_K_UNPRIV, 1'b1, 13'h000, 4'h3, 16'h1, 2'h0);
                3: cset(LSAG_K_PCREL, 1'b1, 13'h0fff, 4'h5, 16'h1, 2'h0);
                4: cset(LSAG_K_PCREL, 1'b1, 13'h1001, 4'h6, 16'h1, 2'h0);
                5: cset(LSAG_K_PAIR, 1'b1, 13'h03fc, 4'h7, 16'h1, 2'h0);
                6: cset(LSAG_K_PAIR, 1'b1, 13'h1c04, 4'h8, 16'h1, 2'h0);
                7: cset(LSAG_K_MULTI, 1'b1, 13'h0, 4'h0, 16'h9001, 2'h1);
                8: cset(LSAG_K_MULTI, 1'b0, 13'h0, 4'h0, 16'h1fee, 2'h3);
                9: cset(LSAG_K_MULTI, 1'b0, 13'h0, 4'h0, 16'h0001, 2'h3);
                default: ;
            endcase
            go();
        end
        close_out();
    end
endmodule
`default_nettype wire
